// file: hw/gims_pkg.sv
/*
  Constants, register map and carrier types of the GPIO interrupt and
  pin-function block. Assumes one 40 MHz clock and a word-wide register port.
*/
package gims_pkg;

  localparam int          NUM_PINS      = 15;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          MODE_W        = 3;
  localparam int          FIELD_STRIDE  = 4;
  localparam int          PINS_PER_WORD = 8;
  localparam int          SEL_W         = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0]  OFS_DATA      = 8'h00;
  localparam logic [7:0]  OFS_OUT_EN    = 8'h04;
  localparam logic [7:0]  OFS_SENSE     = 8'h10;
  localparam logic [7:0]  OFS_BOTH_EDGE = 8'h14;
  localparam logic [7:0]  OFS_POLARITY  = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h1C;
  localparam logic [7:0]  OFS_RAW_STAT  = 8'h20;
  localparam logic [7:0]  OFS_MIS       = 8'h24;
  localparam logic [7:0]  OFS_IRQ_CLR   = 8'h28;
  localparam logic [7:0]  OFS_FUNC_LO   = 8'h2C;
  localparam logic [7:0]  OFS_FUNC_HI   = 8'h30;
  localparam logic [7:0]  OFS_OUT_SET   = 8'h3C;
  localparam logic [7:0]  OFS_OUT_CLR   = 8'h40;
  localparam logic [7:0]  OFS_ROUTING   = 8'h44;

  // ==========================================================================
  // Reset values and write masks
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] RST_FUNC_HI   = 32'h0000_0110;
  localparam logic [31:0] FUNC_WR_MASK  = 32'h7777_7777;
  localparam logic [31:0] FUNC_HI_MASK  = 32'h0777_7777;
  localparam logic [14:0] PIN_MASK_ONE  = 15'h7FFF;

  // ==========================================================================
  // Pin function codes
  typedef enum logic [2:0] {
    GIMS_FN_GPIO    = 3'h0,
    GIMS_FN_SERIAL_FUNCTION_THIRD = 3'h1,
    GIMS_FN_SERIAL_FUNCTION_SECOND = 3'h4,
    GIMS_FN_SERIAL3 = 3'h5
  } gims_func_t;

  // Timer capture modes of the external unit
  localparam logic [2:0]  TMR_MODE_DUAL_CAP   = 3'h2;
  localparam logic [2:0]  TMR_MODE_SINGLE_CAP = 3'h4;
  localparam int          RTE_UA_LSB    = 0;
  localparam int          RTE_UB_LSB    = 8;
  localparam int          RTE_VA_LSB    = 16;
  localparam int          RTE_VB_LSB    = 24;
  localparam logic [7:0]  SEL_MAX       = 8'h0E;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } gims_bus_t;

  typedef struct packed {
    logic        unit1_a;
    logic        unit1_b;
    logic        unit2_a;
    logic        unit2_b;
  } gims_cap_t;

endpackage

// file: hw/gims_top.sv
/*
  GPIO port slice: pin data and direction, per-pin interrupt detection,
  mask and status, pin function select, atomic set/clear of output data
  and capture-input routing to two timer units.
  Assumes pins are asynchronous to mclk and the timer supplies its mode.
*/
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module gims_top #(
  parameter int NPIN = gims_pkg::NUM_PINS
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Register port
  input  wire gims_pkg::gims_bus_t  bus,
  output logic [31:0]               rdata,
  // Pins
  input  wire logic [NPIN-1:0]      pin_in,
  output logic [NPIN-1:0]           pin_out,
  output logic [NPIN-1:0]           pin_oe,
  output logic [NPIN-1:0]           pin_func_gpio,
  // Timer units
  input  wire logic [2:0]           unit1_mode,
  input  wire logic [2:0]           unit2_mode,
  output gims_pkg::gims_cap_t       cap_in,
  // Interrupt
  output logic                      irq
);
  import gims_pkg::*;

  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;
  logic [NPIN-1:0] prev_ff;
  logic [NPIN-1:0] data_ff;
  logic [NPIN-1:0] oen_ff;
  logic [NPIN-1:0] sense_ff;
  logic [NPIN-1:0] both_ff;
  logic [NPIN-1:0] pol_ff;
  logic [NPIN-1:0] mask_ff;
  logic [NPIN-1:0] raw_ff;
  logic [NPIN-1:0] nxt_raw;
  logic [NPIN-1:0] event_hit;
  logic [NPIN-1:0] is_gpio;
  logic [NPIN-1:0] masked;
  logic [31:0]     func_lo_ff;
  logic [31:0]     func_hi_ff;
  logic [31:0]     route_ff;
  logic [31:0]     nxt_rdata;
  logic [31:0]     rdata_ff;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] widen(input logic [NPIN-1:0] v);
    widen = RST_ZERO;
    widen[NPIN-1:0] = v;
  endfunction

  function automatic logic [2:0] pin_func(input int p, input logic [31:0] lo,
                                          input logic [31:0] hi);
    logic [31:0] w;
    w = (p < PINS_PER_WORD) ? lo : hi;
    pin_func = w[(p % PINS_PER_WORD)*FIELD_STRIDE +: MODE_W];
  endfunction

  function automatic logic route_pin(input logic [7:0] sel,
                                     input logic [NPIN-1:0] lv);
    // Codes above the last pin select nothing and read low
    route_pin = (sel <= SEL_MAX) ? lv[sel[3:0]] : 1'b0;
  endfunction

  function automatic logic in_capture(input logic [2:0] m);
    in_capture = (m == TMR_MODE_DUAL_CAP) || (m == TMR_MODE_SINGLE_CAP);
  endfunction

  function automatic logic wr_at(input gims_bus_t b, input logic [7:0] ofs);
    wr_at = b.wr && (b.addr == ofs);
  endfunction

  // ==========================================================================
  // Pin input synchronisers
  // No reset: the chain keeps following the pins through reset, so a pin
  // that idles high does not look like a rising edge once reset is released
  always_ff @(posedge mclk)
  begin
    sync1_ff <= pin_in;
    sync2_ff <= sync1_ff;
    prev_ff  <= sync2_ff;
  end

  // ==========================================================================
  // Function decode
  always_comb
  begin
    for (int p = 0; p < NPIN; p++)
      is_gpio[p] = (pin_func(p, func_lo_ff, func_hi_ff) == GIMS_FN_GPIO);
  end

  assign pin_func_gpio = is_gpio;

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      oen_ff   <= '0;
      sense_ff <= '0;
      both_ff  <= '0;
      pol_ff   <= '0;
      mask_ff  <= '0;
    end
    else
    begin
      if (wr_at(bus, OFS_OUT_EN))    oen_ff   <= bus.wdata[NPIN-1:0];
      if (wr_at(bus, OFS_SENSE))     sense_ff <= bus.wdata[NPIN-1:0];
      if (wr_at(bus, OFS_BOTH_EDGE)) both_ff  <= bus.wdata[NPIN-1:0];
      if (wr_at(bus, OFS_POLARITY))  pol_ff   <= bus.wdata[NPIN-1:0];
      if (wr_at(bus, OFS_IRQ_MASK))  mask_ff  <= bus.wdata[NPIN-1:0];
    end
  end

  // Reserved function bits are cleared on write and read as zero; routing is stored as written
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      func_lo_ff <= RST_ZERO;
      func_hi_ff <= RST_FUNC_HI;
      route_ff   <= RST_ZERO;
    end
    else
    begin
      if (wr_at(bus, OFS_FUNC_LO)) func_lo_ff <= bus.wdata & FUNC_WR_MASK;
      if (wr_at(bus, OFS_FUNC_HI)) func_hi_ff <= bus.wdata & FUNC_HI_MASK;
      if (wr_at(bus, OFS_ROUTING)) route_ff   <= bus.wdata;
    end
  end

  // ==========================================================================
  // Output data with atomic set and clear
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      data_ff <= '0;
    else if (wr_at(bus, OFS_DATA))
      data_ff <= bus.wdata[NPIN-1:0];
    else if (wr_at(bus, OFS_OUT_SET))
      data_ff <= data_ff | (bus.wdata[NPIN-1:0] & is_gpio);
    else if (wr_at(bus, OFS_OUT_CLR))
      data_ff <= data_ff & ~(bus.wdata[NPIN-1:0] & is_gpio);
  end

  // Serial functions own their pins; only GPIO pins are driven here
  assign pin_out = data_ff;
  assign pin_oe  = oen_ff & is_gpio;

  // ==========================================================================
  // Interrupt detection
  always_comb
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      if (sense_ff[p])
        event_hit[p] = (sync2_ff[p] == pol_ff[p]);
      else if (both_ff[p])
        event_hit[p] = (sync2_ff[p] != prev_ff[p]);
      else
        event_hit[p] = (sync2_ff[p] != prev_ff[p]) && (sync2_ff[p] == pol_ff[p]);
    end
  end

  // Set wins over the clear in the same cycle
  always_comb
  begin
    nxt_raw = raw_ff;
    if (wr_at(bus, OFS_IRQ_CLR))
      nxt_raw = nxt_raw & ~bus.wdata[NPIN-1:0];
    nxt_raw = nxt_raw | event_hit;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      raw_ff <= '0;
    else
      raw_ff <= nxt_raw;
  end

  assign masked = raw_ff & mask_ff;
  assign irq    = |masked;

  // ==========================================================================
  // Capture routing
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      cap_in <= '0;
    else
    begin
      cap_in.unit1_a <= in_capture(unit1_mode) &&
                        route_pin(route_ff[RTE_UA_LSB +: SEL_W], sync2_ff);
      cap_in.unit1_b <= in_capture(unit1_mode) &&
                        route_pin(route_ff[RTE_UB_LSB +: SEL_W], sync2_ff);
      cap_in.unit2_a <= in_capture(unit2_mode) &&
                        route_pin(route_ff[RTE_VA_LSB +: SEL_W], sync2_ff);
      cap_in.unit2_b <= in_capture(unit2_mode) &&
                        route_pin(route_ff[RTE_VB_LSB +: SEL_W], sync2_ff);
    end
  end

  // ==========================================================================
  // Register read
  always_comb
  begin
    nxt_rdata = RST_ZERO;
    unique case (bus.addr)
      OFS_DATA:      nxt_rdata = widen(sync2_ff);
      OFS_OUT_EN:    nxt_rdata = widen(oen_ff);
      OFS_SENSE:     nxt_rdata = widen(sense_ff);
      OFS_BOTH_EDGE: nxt_rdata = widen(both_ff);
      OFS_POLARITY:  nxt_rdata = widen(pol_ff);
      OFS_IRQ_MASK:  nxt_rdata = widen(mask_ff);
      OFS_RAW_STAT:  nxt_rdata = widen(raw_ff);
      OFS_MIS:       nxt_rdata = widen(masked);
      OFS_FUNC_LO:   nxt_rdata = func_lo_ff;
      OFS_FUNC_HI:   nxt_rdata = func_hi_ff;
      OFS_ROUTING:   nxt_rdata = route_ff;
      default:       nxt_rdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      rdata_ff <= RST_ZERO;
    else if (bus.rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= RST_ZERO;
  end

  assign rdata = rdata_ff;

endmodule

// file: tb/gims_asserts.sv
/*
  Port checker of gims_top: interrupt, function, output data and capture.
  Bound to every gims_top instance; sees only its ports.
*/
`timescale 1ns/100ps
module gims_asserts #(
  parameter int NPIN = 15
) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                rstn,
  // Observed ports
  input wire gims_pkg::gims_bus_t bus,
  input wire logic [31:0]         rdata,
  input wire logic [NPIN-1:0]     pin_out,
  input wire logic [NPIN-1:0]     pin_oe,
  input wire logic [NPIN-1:0]     pin_func_gpio,
  input wire logic [2:0]          unit1_mode,
  input wire gims_pkg::gims_cap_t cap_in,
  input wire logic                irq
);
  import gims_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Properties
  property p_mask_off;
    bus.wr && bus.addr == OFS_IRQ_MASK && bus.wdata[NPIN-1:0] == '0 |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq high with mask clear");
  property p_mis;
    bus.rd && bus.addr == OFS_MIS |=> rdata[31:NPIN] == '0 && (rdata != 0) == $past(irq);
  endproperty
  a_mis: assert property (p_mis) else $error("status read disagrees with irq");
  property p_func_lo;
    bus.wr && bus.addr == OFS_FUNC_LO |=> pin_func_gpio[0] == ($past(bus.wdata[2:0]) == 3'h0)
      && pin_func_gpio[7] == ($past(bus.wdata[30:28]) == 3'h0);
  endproperty
  a_func_lo: assert property (p_func_lo) else $error("low function decode wrong");
  property p_func_rst;
    !$past(rstn) |-> pin_func_gpio == 15'h79FF;
  endproperty
  a_func_rst: assert property (p_func_rst) else $error("function reset wrong");
  property p_oe;
    (pin_oe & ~pin_func_gpio) == '0;
  endproperty
  a_oe: assert property (p_oe) else $error("non-GPIO pin driven");
  property p_set;
    bus.wr && bus.addr == OFS_OUT_SET
      |=> pin_out == ($past(pin_out) | ($past(bus.wdata[NPIN-1:0]) & $past(pin_func_gpio)));
  endproperty
  a_set: assert property (p_set) else $error("set word result wrong");
  property p_clr;
    bus.wr && bus.addr == OFS_OUT_CLR
      |=> pin_out == ($past(pin_out) & ~($past(bus.wdata[NPIN-1:0]) & $past(pin_func_gpio)));
  endproperty
  a_clr: assert property (p_clr) else $error("clear word result wrong");
  // Both current and last mode checked, so a registered or direct gate both pass
  property p_cap_off;
    !(unit1_mode inside {3'h2, 3'h4}) && !($past(unit1_mode) inside {3'h2, 3'h4})
      |-> !cap_in.unit1_a && !cap_in.unit1_b;
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture routed outside mode");
  c_irq: cover property ($rose(irq));
  c_cap: cover property (cap_in.unit1_a);
  c_set: cover property (bus.wr && bus.addr == OFS_OUT_SET);
endmodule

bind gims_top gims_asserts #(.NPIN(NPIN)) i_gims_asserts (.mclk, .rstn, .bus, .rdata,
  .pin_out, .pin_oe, .pin_func_gpio, .unit1_mode, .cap_in, .irq);

// file: tb/gims_pins.sv
/*
  External circuitry on the IO pins.
  Assumes the bench sets the level of every pin the device leaves undriven.
*/
`timescale 1ns/100ps
module gims_pins #(
  parameter int NPIN = 15
) (
  // Device side
  input  wire logic [NPIN-1:0] pin_out,
  input  wire logic [NPIN-1:0] pin_oe,
  // Bench side
  input  wire logic [NPIN-1:0] ext_lvl,
  output logic [NPIN-1:0]      pin_in
);
  // A driven pin shows the device level, others the outside source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// file: tb/gims_top_tb_top.sv
/*
  Bench of gims_top with a reference model of output data and directed checks of mask and status.
  Assumes the pin model and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
module gims_top_tb_top;
  import gims_pkg::*;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  gims_bus_t   bus = '0;
  logic [31:0] rdata, r;
  logic [14:0] pin_in, pin_out, pin_oe, pin_func_gpio, m_out, ext_lvl = '0;
  logic [2:0]  unit1_mode = 3'h0, unit2_mode = 3'h0;
  gims_cap_t   cap_in;
  logic        irq;
  int          err_total = 0, check_count = 0, cyc = 0;
  logic [7:0]  ra[7] = '{OFS_IRQ_MASK, OFS_MIS, OFS_IRQ_CLR, OFS_FUNC_LO, OFS_FUNC_HI,
                         OFS_ROUTING, 8'hFC};
  logic [31:0] re[7] = '{0, 0, 0, 0, RST_FUNC_HI, 0, 0};
  always #12.5 mclk = ~mclk;
  gims_top i_gims_top (.mclk, .rstn, .bus, .rdata, .pin_in, .pin_out, .pin_oe,
    .pin_func_gpio, .unit1_mode, .unit2_mode, .cap_in, .irq);
  gims_pins i_gims_pins (.pin_out, .pin_oe, .ext_lvl, .pin_in);
  // ==========================================================================
  // Tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held for one edge; the next call or idle replaces it
  task op(input logic [7:0] a, input logic [31:0] d, input logic w);
    bus <= '{a, d, w, !w};
    @(posedge mclk);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    op(a, 32'h0000_0000, 1'b0);
    chk("rdata", rdata, e);
  endtask
  task idle(input int n);
    bus <= '0;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task stop_test;
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      stop_test();
    end
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    r = $urandom(51139);
    repeat (4) @(posedge mclk);
    #1 rstn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
    r = $urandom & 32'h0000_7FFF;
    op(OFS_IRQ_MASK, r, 1'b1);
    rd(OFS_IRQ_MASK, r);
    r = $urandom & FUNC_WR_MASK;
    op(OFS_FUNC_LO, r, 1'b1);
    rd(OFS_FUNC_LO, r);
    op(OFS_FUNC_LO, 32'h0000_0000, 1'b1);
    m_out = '0;
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      op(OFS_OUT_SET, r, 1'b1);
      m_out |= r[14:0] & 15'h79FF;
      r = $urandom;
      op(OFS_OUT_CLR, r, 1'b1);
      m_out &= ~(r[14:0] & 15'h79FF);
      chk("pin_out", pin_out, m_out);
    end
    ext_lvl <= 15'($urandom);
    op(OFS_OUT_EN, 32'h0000_7FFF, 1'b1);
    idle(3);
    chk("pin_oe", pin_oe, 15'h79FF);
    rd(OFS_DATA, m_out | (ext_lvl & 15'h0600));
    op(OFS_OUT_EN, 32'h0000_0000, 1'b1);
    ext_lvl <= '0;
    op(OFS_POLARITY, 32'h0000_0008, 1'b1);
    op(OFS_IRQ_MASK, 32'h0000_0018, 1'b1);
    idle(4);
    op(OFS_IRQ_CLR, 32'h0000_7FFF, 1'b1);
    chk("irq", irq, 0);
    ext_lvl <= 15'h0018;
    idle(4);
    chk("irq", irq, 1);
    rd(OFS_MIS, 32'h0000_0008);
    op(OFS_IRQ_CLR, 32'h0000_0010, 1'b1);
    chk("irq", irq, 1);
    op(OFS_IRQ_CLR, 32'h0000_0008, 1'b1);
    chk("irq", irq, 0);
    op(OFS_SENSE, 32'h0000_0008, 1'b1);
    idle(3);
    op(OFS_IRQ_CLR, 32'h0000_0008, 1'b1);
    chk("irq", irq, 1);
    op(OFS_IRQ_MASK, 32'h0000_0000, 1'b1);
    chk("irq", irq, 0);
    op(OFS_ROUTING, 32'h050F_0E05, 1'b1);
    rd(OFS_ROUTING, 32'h050F_0E05);
    unit1_mode <= 3'h2;
    unit2_mode <= 3'h4;
    ext_lvl <= 15'h4020;
    idle(4);
    chk("cap_in", cap_in, 32'h0000_000D);
    unit1_mode <= 3'h3;
    idle(2);
    chk("cap_in", cap_in, 32'h0000_0001);
    r = $urandom & FUNC_HI_MASK;
    op(OFS_FUNC_HI, r, 1'b1);
    rd(OFS_FUNC_HI, r);
    for (int p = PINS_PER_WORD; p < NUM_PINS; p++)
      chk("pin_func_gpio", pin_func_gpio[p],
          r[(p - PINS_PER_WORD) * FIELD_STRIDE +: MODE_W] == GIMS_FN_GPIO);
    op(OFS_DATA, 32'h0000_2A5A, 1'b1);
    chk("pin_out", pin_out, 32'h0000_2A5A);
    stop_test();
  end
endmodule
